/* File: logic/vbr_byte_fetch.sv */
// one physical byte access to the rom: enable window and byte capture
// assumes the rom drives its data while the output enable is low
`default_nettype none
module vbr_byte_fetch (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_start,
  input  wire logic [3:0] i_win,
  input  wire logic [7:0] i_rom_data,
  output logic            o_rom_output_enable_n,
  output logic [7:0]      o_byte,
  output logic            o_done
);
  import vbr_pkg::*;

  logic [3:0] cnt_r;
  logic [7:0] byte_r;
  wire        busy    = (cnt_r != 4'h0);
  wire        capture = (cnt_r == CAPTURE_AT);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_r <= 4'h0;
    end else if (i_start && !busy) begin
      cnt_r <= i_win;
    end else if (busy) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // data latched one clock before the enable goes away
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      byte_r <= 8'h00;
    end else if (capture) begin
      byte_r <= i_rom_data;
    end
  end

  assign o_rom_output_enable_n = !busy;
  assign o_byte                = byte_r;
  assign o_done                = (cnt_r == 4'h1);

  a_capture_before_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
    capture |=> !o_rom_output_enable_n ##1 o_rom_output_enable_n)
    else $error("byte capture not one clock before enable release");
endmodule : vbr_byte_fetch
`default_nettype wire

/* File: logic/vbr_pkg.sv */
// shared constants and types for the boot rom read interface
// assumes one 40 MHz clock that also serves as the bus clock
`default_nettype none
package vbr_pkg;
  // configuration space index of the rom base address register
  localparam logic [7:0]  ROM_BAR_OFS   = 8'h30;
  localparam logic [31:0] ROM_BAR_RST   = 32'h0000_0000;
  // writable bits: enable in bit 0, 64 KB aligned base in 31:16
  localparam logic [31:0] ROM_BAR_WMASK = 32'hFFFF_0001;
  localparam int          BAR_EN_BIT    = 0;
  localparam int          STRAP_ROM_BIT = 4;
  localparam logic [1:0]  PORT_SEL_GOP2 = 2'h3;
  // rom access window per byte, in bus clocks
  localparam int          WIN_SINGLE_CLK = 14;
  localparam int          WIN_MULTI_CLK  = 10;
  localparam logic [3:0]  WIN_SINGLE = 4'(WIN_SINGLE_CLK);
  localparam logic [3:0]  WIN_MULTI  = 4'(WIN_MULTI_CLK);
  // capture happens when this many window clocks remain
  localparam logic [3:0]  CAPTURE_AT = 4'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  be_n;
  } vbr_req_t;

  typedef enum logic [1:0] {
    VBR_IDLE,
    VBR_START,
    VBR_BUSY,
    VBR_RESP
  } vbr_state_t;
endpackage : vbr_pkg
`default_nettype wire

/* File: logic/vbr_rom_read.sv */
// boot rom read path: pci byte assembly and vl-bus chip select
// assumes pci request is a one-cycle pulse from the target decoder,
// and config writes arrive as single-cycle strobes with byte enables
`default_nettype none
module vbr_rom_read (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_pci_mode,
  input  wire logic [7:0]        i_strap_config_register,
  input  wire logic [1:0]        i_output_port_select,
  input  wire logic              i_gop_bit1,
  input  wire logic              i_cfg_wr,
  input  wire logic [7:0]        i_cfg_index,
  input  wire logic [3:0]        i_cfg_be_n,
  input  wire logic [31:0]       i_cfg_wdata,
  output logic [31:0]            o_cfg_rdata,
  input  wire logic              i_pci_req,
  input  wire vbr_pkg::vbr_req_t i_pci_cmd,
  output logic                   o_pci_claim,
  output logic                   o_pci_trdy,
  output logic [31:0]            o_pci_ad,
  output logic [15:0]            o_general_address_bus,
  output logic                   o_general_address_oe,
  input  wire logic [7:0]        i_general_data_bus,
  output logic                   o_rom_output_enable_n,
  input  wire logic              i_isa_rom_addr_valid,
  output logic                   o_pin153
);
  import vbr_pkg::*;

  // counts enabled lanes of an active-low byte enable field
  function automatic logic [2:0] lane_count(input logic [3:0] be_n);
    lane_count = 3'(!be_n[0]) + 3'(!be_n[1]) + 3'(!be_n[2]) + 3'(!be_n[3]);
  endfunction : lane_count

  // lowest enabled lane
  function automatic logic [1:0] first_lane(input logic [3:0] be_n);
    if (!be_n[0]) begin
      first_lane = 2'd0;
    end else if (!be_n[1]) begin
      first_lane = 2'd1;
    end else if (!be_n[2]) begin
      first_lane = 2'd2;
    end else begin
      first_lane = 2'd3;
    end
  endfunction : first_lane

  logic [31:0] bar_r;
  vbr_state_t  state_r;
  logic [15:0] addr_r;
  logic [1:0]  lane_r;
  logic [2:0]  left_r;
  logic [3:0]  win_r;
  logic [31:0] data_r;
  logic [7:0]  fetched;
  logic        fetch_done;
  logic        rom_oe_n;

  // config write: only enable and base bits are writable
  wire         bar_sel = i_cfg_wr && (i_cfg_index == ROM_BAR_OFS);
  wire  [31:0] be_mask = {{8{!i_cfg_be_n[3]}}, {8{!i_cfg_be_n[2]}},
                          {8{!i_cfg_be_n[1]}}, {8{!i_cfg_be_n[0]}}};
  wire  [31:0] wmask   = be_mask & ROM_BAR_WMASK;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      bar_r <= ROM_BAR_RST;
    end else if (bar_sel) begin
      bar_r <= (bar_r & ~wmask) | (i_cfg_wdata & wmask);
    end
  end

  assign o_cfg_rdata = (i_cfg_index == ROM_BAR_OFS) ? bar_r : 32'h0000_0000;

  // enable sources differ by bus type
  wire pci_rom_en = i_pci_mode && bar_r[BAR_EN_BIT];
  wire vl_rom_en  = !i_pci_mode
                    && i_strap_config_register[STRAP_ROM_BIT];

  wire [2:0] req_lanes = lane_count(i_pci_cmd.be_n);
  wire       bar_hit   = (i_pci_cmd.addr[31:16] == bar_r[31:16]);
  wire       req_hit   = bar_hit && (req_lanes != 3'd0);
  // a disabled rom never claims its window a busy block
  // refuses too, so a claimed request is never silently dropped
  assign o_pci_claim = i_pci_req && pci_rom_en && req_hit
                       && (state_r == VBR_IDLE);
  wire   accept      = o_pci_claim;

  // one byte per window; multi-byte reads use the shorter window
  wire [3:0] req_win   = (req_lanes == 3'd1) ? WIN_SINGLE
                                             : WIN_MULTI;
  wire       fetch_go  = (state_r == VBR_START);
  wire       last_byte = (left_r == 3'd1);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= VBR_IDLE;
    end else begin
      case (state_r)
        VBR_IDLE: begin
          if (accept) begin
            state_r <= VBR_START;
          end
        end
        VBR_START: begin
          state_r <= VBR_BUSY;
        end
        VBR_BUSY: begin
          if (fetch_done) begin
            state_r <= last_byte ? VBR_RESP : VBR_START;
          end
        end
        default: begin
          state_r <= VBR_IDLE;
        end
      endcase
    end
  end

  // width from byte enables; low address steps once per byte
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      addr_r <= 16'h0000;
      lane_r <= 2'd0;
      left_r <= 3'd0;
      win_r  <= WIN_SINGLE;
    end else if (accept) begin
      lane_r <= first_lane(i_pci_cmd.be_n);
      left_r <= req_lanes;
      win_r  <= req_win;
      addr_r <= {i_pci_cmd.addr[15:2], first_lane(i_pci_cmd.be_n)};
    end else if ((state_r == VBR_BUSY) && fetch_done && !last_byte) begin
      addr_r <= addr_r + 16'h0001;
      lane_r <= lane_r + 2'd1;
      left_r <= left_r - 3'd1;
    end
  end

  // each captured byte lands in its own lane of the ad word
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      data_r <= 32'h0000_0000;
    end else if (accept) begin
      data_r <= 32'h0000_0000;
    end else if ((state_r == VBR_BUSY) && fetch_done) begin
      data_r[8*lane_r +: 8] <= fetched;
    end
  end

  vbr_byte_fetch u_fetch (
    .i_clk                 (i_clk),
    .i_nrst                (i_nrst),
    .i_start               (fetch_go),
    .i_win                 (win_r),
    .i_rom_data            (i_general_data_bus),
    .o_rom_output_enable_n (rom_oe_n),
    .o_byte                (fetched),
    .o_done                (fetch_done)
  );

  // the shared pixel pins carry the rom address only during a read
  wire pci_busy = (state_r == VBR_START) || (state_r == VBR_BUSY);
  assign o_general_address_bus = addr_r;
  assign o_general_address_oe  = pci_busy && pci_rom_en;
  assign o_rom_output_enable_n = rom_oe_n || !pci_rom_en;
  assign o_pci_trdy            = (state_r == VBR_RESP);
  assign o_pci_ad              = data_r;

  // vl-bus: chip select follows the decoded address, active low;
  // it enables the rom and its data buffer for the isa read
  wire rom_cs_n = !(vl_rom_en && i_isa_rom_addr_valid);
  assign o_pin153 = (i_output_port_select == PORT_SEL_GOP2)
                    ? i_gop_bit1 : rom_cs_n;

  // helper counter of clocks with the rom enabled during one request
  logic [5:0] oe_clks_r;
  logic [2:0] lanes_r;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      oe_clks_r <= 6'd0;
      lanes_r   <= 3'd0;
    end else if (accept) begin
      oe_clks_r <= 6'd0;
      lanes_r   <= req_lanes;
    end else if (!o_rom_output_enable_n) begin
      oe_clks_r <= oe_clks_r + 6'd1;
    end
  end

  // length of each enable-low run, judged where the run ends
  logic [3:0] oe_run_r;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      oe_run_r <= 4'h0;
    end else if (!rom_oe_n) begin
      oe_run_r <= oe_run_r + 4'h1;
    end else begin
      oe_run_r <= 4'h0;
    end
  end

  a_trdy_after_all: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pci_trdy |-> $past(left_r) == 3'd1)
    else $error("trdy before the last byte");
  a_disabled_no_claim: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    !pci_rom_en |-> !o_pci_claim && o_rom_output_enable_n)
    else $error("rom active while disabled");
  a_bar_gates_pci: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_pci_mode && !bar_r[0]) |-> !o_pci_claim)
    else $error("claim with base register disabled");
  a_strap_gates_cs: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_pci_mode && !i_strap_config_register[4]
     && i_output_port_select != 2'h3) |-> o_pin153)
    else $error("chip select with strap low");
  a_pin153_gop: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_output_port_select == 2'h3) |-> o_pin153 == i_gop_bit1)
    else $error("pin 153 not following output bit");
  a_cs_follows_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_pci_mode && i_strap_config_register[4] && i_isa_rom_addr_valid
     && i_output_port_select != 2'h3) |-> !o_pin153)
    else $error("chip select missing while address valid");
  a_single_window: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (accept && lane_count(i_pci_cmd.be_n) == 3'd1)
    |-> ##[16:16] o_pci_trdy)
    else $error("single byte read not 14 clock window");
  a_word_window: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (accept && i_pci_cmd.be_n == 4'h0) |-> ##[45:45] o_pci_trdy)
    else $error("32-bit read timing wrong");
  a_half_window: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (accept && i_pci_cmd.be_n == 4'hC) |-> ##[23:23] o_pci_trdy)
    else $error("16-bit read timing wrong");
  a_oe_total: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pci_trdy |-> oe_clks_r == 6'(win_r) * 6'(lanes_r))
    else $error("enable clocks not a whole number of windows");
  a_addr_steps: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r == VBR_BUSY && fetch_done && left_r > 3'd1)
    |=> o_general_address_bus == $past(addr_r) + 16'h0001)
    else $error("low address did not step");
  a_width_decode: assert property (@(posedge i_clk) disable iff (!i_nrst)
    accept |=> left_r == lane_count($past(i_pci_cmd.be_n)))
    else $error("read width not from byte enables");

  // read timing, byte assembly and claim refusal
  a_oe_run_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(rom_oe_n) |-> oe_run_r == win_r)
    else $error("byte window length differs from the selected window");
  a_three_window: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (accept && lane_count(i_pci_cmd.be_n) == 3'd3)
    |-> ##[34:34] o_pci_trdy)
    else $error("24-bit read timing wrong");
  a_trdy_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pci_trdy |=> !o_pci_trdy)
    else $error("target ready longer than one clock");
  a_busy_no_claim: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r != VBR_IDLE) |-> !o_pci_claim)
    else $error("request claimed while a read is under way");
  a_ad_cleared: assert property (@(posedge i_clk) disable iff (!i_nrst)
    accept |=> o_pci_ad == 32'h0000_0000)
    else $error("stale data left on ad at the start of a read");
  a_lane0_fill: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r == VBR_BUSY && fetch_done && lane_r == 2'd0)
    |=> o_pci_ad[7:0] == $past(fetched))
    else $error("first lane not filled from the rom byte");
  a_lane3_fill: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r == VBR_BUSY && fetch_done && lane_r == 2'd3)
    |=> o_pci_ad[31:24] == $past(fetched))
    else $error("top lane not filled from the rom byte");
  a_claim_needs_lanes: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    o_pci_claim |-> i_pci_cmd.be_n != 4'hF)
    else $error("claim without any enabled byte lane");

  // pin ownership
  a_oe_has_addr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_rom_output_enable_n |-> o_general_address_oe)
    else $error("rom enabled without the address pins driven");
  a_addr_first_lane: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    accept |=> o_general_address_bus[1:0]
               == first_lane($past(i_pci_cmd.be_n)))
    else $error("first byte address not at the lowest enabled lane");
  a_pins_free_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_r == VBR_IDLE) |-> !o_general_address_oe)
    else $error("address pins driven with no read under way");
  a_pci_no_cs: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_pci_mode && i_output_port_select != PORT_SEL_GOP2)
    |-> o_pin153)
    else $error("chip select active in a pci configuration");
  a_vl_no_pci: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_pci_mode |-> !o_pci_claim && !o_general_address_oe)
    else $error("pci rom path active in a vl-bus configuration");
endmodule : vbr_rom_read
`default_nettype wire

/* File: test/vbr_rom_model.sv */
// byte-wide boot rom model answering on the general address/data buses
// assumes the block drives the address and an active-low output enable
`default_nettype none
module vbr_rom_model (
  input  wire logic [15:0] i_addr,
  input  wire logic        i_oe_n,
  output logic [7:0]       o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last = 8'h00;
  // a released rom floats: show the inverse of the last byte, never a copy
  always @* begin
    if (!i_oe_n) begin
      last = i_addr[7:0] ^ i_addr[15:8] ^ 8'hA5;
      o_data = last;
    end else begin
      o_data = ~last;
    end
  end
endmodule : vbr_rom_model
`default_nettype wire

/* File: test/vbr_rom_read_tb.sv */
// self-checking bench for the boot rom read path
// assumes the rom model file is compiled before this one
`default_nettype none
module vbr_rom_read_tb;
  import vbr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_nrst, i_pci_mode, i_gop_bit1, i_cfg_wr, i_pci_req;
  logic i_isa_rom_addr_valid, o_pci_claim, o_pci_trdy;
  logic o_general_address_oe, o_rom_output_enable_n, o_pin153;
  logic [7:0]  i_strap_config_register, i_cfg_index, i_general_data_bus;
  logic [1:0]  i_output_port_select;
  logic [3:0]  i_cfg_be_n;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, o_pci_ad;
  logic [15:0] o_general_address_bus;
  vbr_req_t    i_pci_cmd;
  int bad_count = 0, num_checks = 0, oe_cnt = 0, addr_bad = 0, cur_nb = 0;
  logic [15:0] cur_a = 16'h0000;

  vbr_rom_read DUT (.*);
  vbr_rom_model ROM (.i_addr(o_general_address_bus),
    .i_oe_n(o_rom_output_enable_n), .o_data(i_general_data_bus));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // rom enable must only open on a requested byte with pins driven
  always @(negedge i_clk) begin
    if (!o_rom_output_enable_n) begin
      oe_cnt++;
      if (o_general_address_bus - cur_a >= 16'(cur_nb) ||
          o_general_address_oe !== 1'b1) addr_bad++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic cfg_wr(input logic [7:0] idx, input logic [3:0] be,
                        input logic [31:0] d);
    @(negedge i_clk);
    {i_cfg_wr, i_cfg_index, i_cfg_be_n, i_cfg_wdata} = {1'b1, idx, be, d};
    @(negedge i_clk);
    i_cfg_wr = 1'b0;
  endtask : cfg_wr

  // single request cycle; returns whether the block claimed it
  task automatic req(input logic [31:0] a, input logic [3:0] be,
                     output logic claim);
    @(negedge i_clk);
    i_pci_req = 1'b1;
    i_pci_cmd = '{addr: a, be_n: be};
    #1 claim = o_pci_claim;
    @(negedge i_clk);
    i_pci_req = 1'b0;
  endtask : req

  task automatic pci_read(input logic [31:0] a, input logic [3:0] be,
                          input int nb);
    logic [31:0] exp;
    logic [31:0] msk;
    logic        cl;
    int          n;
    int          w;
    w = (nb == 1) ? WIN_SINGLE_CLK : WIN_MULTI_CLK;
    exp = 32'h0000_0000;
    msk = 32'hFFFF_FFFF >> (32 - 8*nb);
    for (int i = 0; i < nb; i++) begin
      exp[8*i +: 8] = (a[7:0] + 8'(i)) ^ a[15:8] ^ 8'hA5;
    end
    {cur_a, cur_nb, oe_cnt, addr_bad} = {a[15:0], nb, 32'd0, 32'd0};
    req(a, be, cl);
    chk(32'(cl), 32'd1);
    n = 1;
    while (o_pci_trdy !== 1'b1 && n < 80) begin
      @(negedge i_clk);
      n++;
    end
    chk(n, nb * (w + 1) + 1);
    chk(o_pci_ad & msk, exp);
    chk(oe_cnt, nb * w);
    chk(addr_bad, 0);
  endtask : pci_read

  task automatic t_config;
    logic cl;
    req(32'hABCD_0000, 4'b0000, cl);
    chk(32'(cl), 32'd0);
    i_cfg_index = ROM_BAR_OFS;
    #1 chk(o_cfg_rdata, ROM_BAR_RST);
    cfg_wr(ROM_BAR_OFS, 4'b0000, 32'hABCD_FFFF);
    chk(o_cfg_rdata, 32'hABCD_0001);
    cfg_wr(ROM_BAR_OFS, 4'b0111, 32'h1200_0000);
    chk(o_cfg_rdata, 32'h12CD_0001);
    cfg_wr(8'h10, 4'b0000, 32'hFFFF_FFFF);
    chk(o_cfg_rdata, 32'h0000_0000);
    i_cfg_index = ROM_BAR_OFS;
    #1 chk(o_cfg_rdata, 32'h12CD_0001);
    cfg_wr(ROM_BAR_OFS, 4'b0000, 32'hABCD_0001);
  endtask : t_config

  task automatic t_refuse;
    logic cl;
    int   t;
    req(32'hABCD_0040, 4'b0000, cl);
    chk(32'(cl), 32'd1);
    repeat (5) @(negedge i_clk);
    req(32'hABCD_0080, 4'b1110, cl);
    chk(32'(cl), 32'd0);
    t = 0;
    repeat (120) begin
      @(negedge i_clk);
      t += int'(o_pci_trdy);
    end
    chk(t, 1);
    req(32'h1234_0000, 4'b1110, cl);
    chk(32'(cl), 32'd0);
    req(32'hABCD_0000, 4'b1111, cl);
    chk(32'(cl), 32'd0);
    // host shadowed the rom and now turns access off
    cfg_wr(ROM_BAR_OFS, 4'b1110, 32'h0000_0000);
    req(32'hABCD_0000, 4'b0000, cl);
    chk(32'(cl), 32'd0);
    repeat (20) @(negedge i_clk);
    chk(32'(o_rom_output_enable_n), 32'd1);
  endtask : t_refuse

  task automatic t_vlbus;
    @(negedge i_clk);
    {i_pci_mode, i_strap_config_register, i_isa_rom_addr_valid} = 10'h021;
    @(negedge i_clk);
    chk(32'(o_pin153), 32'd0);
    i_isa_rom_addr_valid = 1'b0;
    @(negedge i_clk);
    chk(32'(o_pin153), 32'd1);
    // merged firmware board: strap tied low
    {i_strap_config_register, i_isa_rom_addr_valid} = 9'h001;
    @(negedge i_clk);
    chk(32'(o_pin153), 32'd1);
    i_output_port_select = PORT_SEL_GOP2;
    for (int v = 0; v < 2; v++) begin
      i_gop_bit1 = 1'(v);
      @(negedge i_clk);
      chk(32'(o_pin153), 32'(v));
    end
  endtask : t_vlbus

  initial begin
    {i_nrst, i_pci_mode, i_gop_bit1, i_cfg_wr, i_pci_req} = 5'b01000;
    {i_isa_rom_addr_valid, i_strap_config_register} = 9'h000;
    {i_output_port_select, i_cfg_be_n} = 6'h0F;
    {i_cfg_index, i_cfg_wdata} = 40'h0;
    i_pci_cmd = '{addr: 32'h0, be_n: 4'hF};
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    t_config();
    pci_read(32'hABCD_1230, 4'b1110, 1);
    pci_read(32'hABCD_3F10, 4'b1100, 2);
    pci_read(32'hABCD_00FC, 4'b1000, 3);
    pci_read(32'hABCD_8A04, 4'b0000, 4);
    t_refuse();
    t_vlbus();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    bad_count++;
    end_of_test();
  end
endmodule : vbr_rom_read_tb
`default_nettype wire
